/* File: src/apd_cfg.svh */
/*
  Offsets, reset values, field positions and timing counts of the amplifier
  protection and load-diagnostic block. Assumes a 20 MHz system clock.
*/
`ifndef APD_CFG_SVH
`define APD_CFG_SVH

`define APD_CLK_HZ 20000000
`define APD_DIAG_TIME_MS 229
`define APD_DIAG_CYCLES (`APD_DIAG_TIME_MS * (`APD_CLK_HZ / 1000))
`define APD_CHECK_TIME_US 500
`define APD_CHECK_CYCLES (`APD_CHECK_TIME_US * (`APD_CLK_HZ / 1000000))
`define APD_CHECK_TRIES 3'h5

`define APD_REG_FAULT 8'h00
`define APD_REG_DIAG 8'h01
`define APD_REG_LIMIT 8'h03
`define APD_LIMIT_RST 8'h3F
`define APD_LIMIT_MSB 5

`define APD_PWM_MID 9'h080
`define APD_I2C_ADDR 7'h2A

`endif

/* File: src/apd_pkg.sv */
/*
  Types shared by the amplifier protection block: event and diagnostic
  carriers, pin bundle, state enumerations and the load classifier.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package apd_pkg;

  typedef struct packed {
    logic oc;
    logic dc;
    logic ot;
    logic uv;
    logic ov;
  } apd_evt_t;

  typedef struct packed {
    logic short_gnd;
    logic short_supply;
    logic shorted_load;
    logic open_load;
  } apd_diag_t;

  typedef struct packed {
    logic standby_n;
    apd_evt_t evt;
    apd_diag_t cmp;
    logic large_cap;
    logic scl;
    logic sda;
  } apd_pins_t;

  typedef enum logic [2:0] {ST_SHDN, ST_BIAS, ST_CHECK, ST_PLAY, ST_PROT, ST_LOADF} apd_state_t;

  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_REG, I_WACK, I_WDATA, I_RDATA, I_RACK} apd_i2c_t;

  // Worst condition wins so that at most one result is reported
  function automatic apd_diag_t apd_classify(input apd_diag_t c);
    apd_diag_t r;
    r = '0;
    if (c.short_gnd) r.short_gnd = 1'b1;
    else if (c.short_supply) r.short_supply = 1'b1;
    else if (c.shorted_load) r.shorted_load = 1'b1;
    else if (c.open_load) r.open_load = 1'b1;
    return r;
  endfunction : apd_classify

endpackage : apd_pkg

/* File: src/apd_top.sv */
/*
  Supervisory logic of a mono bridge amplifier: load diagnostic sequencer,
  protection handling, fault pin, register file over a two-wire serial port,
  output limiter and complementary PWM.
  Assumes analog comparator flags and pins arrive asynchronously, audio
  samples arrive on clk, and the pad ring resolves the open-drain lines.
*/
// Functional notes
// - Diagnostic starts on standby release or fault
// - Both outputs high impedance during diagnostic
// - At most one load result is reported
// - One diagnostic run lasts 229 ms
// - Check phase runs up to five times
// - Open load still lets audio play
// - Normal load result starts driving audio
// - Overvoltage reruns diagnostic every second event
// - Open load reported by status only
// - Temperature or supply faults abort diagnostic
// - Overcurrent: high impedance, fault pin, status
// - DC offset watched during play, flagged
// - Overtemperature shuts down, recovers by itself
// - Undervoltage asserts fault, resets limit and fault status
// - Reset releases serial lines, registers default
// - Overvoltage asserts fault and status bit
// - One limit magnitude for both polarities
// - Zero input gives in-phase PWM outputs
// - Duty above half for matching polarity
// - Fault pin active-low open drain
// - Standby pin low shuts device down
`timescale 1ns/10ps
`include "apd_cfg.svh"

module apd_top
  import apd_pkg::*;
#(
  parameter int TW = 23,
  parameter int DIAG_CYCLES = `APD_DIAG_CYCLES,
  parameter int CHECK_CYCLES = `APD_CHECK_CYCLES,
  parameter logic [6:0] DEV_ADDR = `APD_I2C_ADDR
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control pin and protection comparators
  input wire logic standby_n,
  input wire logic overcurrent_shutdown,
  input wire logic dc_offset_detect,
  input wire logic overtemperature_shutdown,
  input wire logic supply_low_event,
  input wire logic supply_high_event,
  // Load diagnostic comparators
  input wire logic diag_short_gnd,
  input wire logic diag_short_supply,
  input wire logic diag_shorted_load,
  input wire logic diag_open_load,
  input wire logic diag_large_cap,
  // Audio sample, signed
  input wire logic [7:0] audio_level,
  // Serial register port
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Fault indicator, open drain
  output logic fault_n_o,
  output logic fault_n_oe,
  // Bridge outputs
  output logic bridge_out_pos,
  output logic bridge_out_pos_oe,
  output logic bridge_out_neg,
  output logic bridge_out_neg_oe
);

  logic rst_s1_q, rst_n_q;
  apd_pins_t raw, s1_q, s2_q, s3_q, f_q, fp_q;
  apd_state_t st_q;
  apd_i2c_t i2_q;
  logic [TW-1:0] tmr_q;
  logic [2:0] tries_q;
  logic ov_par_q, ov_skip_q, prot_other_q;
  apd_evt_t fault_stat_q;
  apd_diag_t diag_stat_q, cls;
  logic [7:0] lim_q, ptr_q, shift_q, tx_q, wr_addr_q, wr_data_q, rd_cur, rd_nxt;
  logic [3:0] bit_q;
  logic rw_q, nack_q, wr_stb_q;
  logic [7:0] pwm_cnt_q;
  logic signed [8:0] smp, lim_s, a_cl, duty_p, duty_n;
  logic abort, prot_any, ov_rise, scl_rise, scl_fall, i2_start, i2_stop, load_fault;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Three-flop input filter; a bit rises only once stages two and three agree, and falls as soon as they differ
  assign raw = {standby_n, overcurrent_shutdown, dc_offset_detect, overtemperature_shutdown,
                supply_low_event, supply_high_event, diag_short_gnd, diag_short_supply,
                diag_shorted_load, diag_open_load, diag_large_cap, scl_i, sda_i};

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      f_q <= '0;
      fp_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (f_q & ~(s2_q ^ s3_q));
      fp_q <= f_q;
    end
  end

  assign cls = apd_classify(f_q.cmp);
  assign load_fault = cls.short_gnd | cls.short_supply | cls.shorted_load;
  assign abort = f_q.evt.ot | f_q.evt.ov | f_q.evt.uv;
  // DC offset only counts while audio is being driven
  assign prot_any = f_q.evt.oc | f_q.evt.ot | f_q.evt.uv | f_q.evt.ov | (f_q.evt.dc & (st_q == ST_PLAY));
  assign ov_rise = f_q.evt.ov & ~fp_q.evt.ov;

  // Diagnostic sequencer and protection states
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ST_SHDN;
      tmr_q <= '0;
      tries_q <= '0;
      diag_stat_q <= '0;
    end else if (!f_q.standby_n) begin
      st_q <= ST_SHDN;
    end else begin
      unique case (st_q)
        ST_SHDN: begin
          st_q <= ST_BIAS;
          tmr_q <= TW'(DIAG_CYCLES - CHECK_CYCLES - 1);
          tries_q <= '0;
        end
        ST_BIAS: begin
          if (abort) st_q <= ST_PROT;
          else if (tmr_q == '0) begin
            st_q <= ST_CHECK;
            tmr_q <= TW'(CHECK_CYCLES - 1);
          end else tmr_q <= tmr_q - 1'b1;
        end
        ST_CHECK: begin
          if (abort) st_q <= ST_PROT;
          else if (tmr_q != '0) tmr_q <= tmr_q - 1'b1;
          else if ((load_fault | f_q.large_cap) && tries_q < `APD_CHECK_TRIES - 3'h1) begin
            tries_q <= tries_q + 3'h1;
            tmr_q <= TW'(CHECK_CYCLES - 1);
          end else begin
            diag_stat_q <= cls;
            st_q <= load_fault ? ST_LOADF : ST_PLAY;
          end
        end
        ST_PLAY: begin
          if (prot_any) st_q <= ST_PROT;
        end
        ST_PROT: begin
          // Recovery is automatic once overcurrent, temperature and supply causes have gone; dc offset is not waited for
          if (!(f_q.evt.oc | f_q.evt.ot | f_q.evt.uv | f_q.evt.ov)) begin
            if (ov_skip_q && !prot_other_q) st_q <= ST_PLAY;
            else begin
              st_q <= ST_BIAS;
              tmr_q <= TW'(DIAG_CYCLES - CHECK_CYCLES - 1);
              tries_q <= '0;
            end
          end
        end
        ST_LOADF: begin
          // Held until the standby pin cycles; a wiring fault needs service
          st_q <= ST_LOADF;
        end
      endcase
    end
  end

  // Overvoltage alternation and fault cause bookkeeping
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ov_par_q <= 1'b0;
      ov_skip_q <= 1'b0;
      prot_other_q <= 1'b0;
    end else begin
      if (ov_rise) begin
        ov_par_q <= ~ov_par_q;
        ov_skip_q <= ~ov_par_q;
      end
      if (st_q != ST_PROT) prot_other_q <= 1'b0;
      if (f_q.evt.oc | f_q.evt.ot | f_q.evt.uv | (f_q.evt.dc & (st_q == ST_PLAY))) prot_other_q <= 1'b1;
    end
  end

  // Register file; undervoltage returns the limit to its default and clears every fault flag except uv
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lim_q <= `APD_LIMIT_RST;
      fault_stat_q <= '0;
    end else if (f_q.evt.uv) begin
      lim_q <= `APD_LIMIT_RST;
      fault_stat_q <= '0;
      fault_stat_q.uv <= 1'b1;
    end else begin
      if (wr_stb_q && wr_addr_q == `APD_REG_LIMIT) lim_q <= wr_data_q;
      // Set only; no software clear, so no set/clear race
      if (f_q.evt.oc) fault_stat_q.oc <= 1'b1;
      if (f_q.evt.dc && st_q == ST_PLAY) fault_stat_q.dc <= 1'b1;
      if (f_q.evt.ot) fault_stat_q.ot <= 1'b1;
      if (f_q.evt.ov) fault_stat_q.ov <= 1'b1;
    end
  end

  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == `APD_REG_FAULT) r = {3'h0, fault_stat_q};
    else if (a == `APD_REG_DIAG) r = {4'h0, diag_stat_q};
    else if (a == `APD_REG_LIMIT) r = lim_q;
    return r;
  endfunction : rd_reg

  assign rd_cur = rd_reg(ptr_q);
  assign rd_nxt = rd_reg(ptr_q + 8'h01);
  assign scl_rise = f_q.scl & ~fp_q.scl;
  assign scl_fall = ~f_q.scl & fp_q.scl;
  assign i2_start = f_q.scl & fp_q.scl & fp_q.sda & ~f_q.sda;
  assign i2_stop = f_q.scl & fp_q.scl & ~fp_q.sda & f_q.sda;

  // Serial slave; data changes only after SCL falls, which gives the hold time
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      i2_q <= I_IDLE;
      bit_q <= '0;
      shift_q <= '0;
      tx_q <= '0;
      ptr_q <= '0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      wr_stb_q <= 1'b0;
      if (i2_start) begin
        i2_q <= I_ADDR;
        bit_q <= '0;
        sda_oe <= 1'b0;
      end else if (i2_stop) begin
        i2_q <= I_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        bit_q <= bit_q + 4'h1;
        if (i2_q == I_ADDR || i2_q == I_REG || i2_q == I_WDATA) shift_q <= {shift_q[6:0], f_q.sda};
        if (i2_q == I_RACK) nack_q <= f_q.sda;
      end else if (scl_fall) begin
        unique case (i2_q)
          I_IDLE: ;
          I_ADDR: if (bit_q == 4'h8) begin
            bit_q <= '0;
            if (shift_q[7:1] == DEV_ADDR) begin
              rw_q <= shift_q[0];
              sda_oe <= 1'b1;
              i2_q <= I_AACK;
            end else i2_q <= I_IDLE;
          end
          I_AACK: if (bit_q == 4'h1) begin
            bit_q <= '0;
            if (rw_q) begin
              tx_q <= rd_cur;
              sda_oe <= ~rd_cur[7];
              i2_q <= I_RDATA;
            end else begin
              sda_oe <= 1'b0;
              i2_q <= I_REG;
            end
          end
          I_REG: if (bit_q == 4'h8) begin
            bit_q <= '0;
            ptr_q <= shift_q;
            sda_oe <= 1'b1;
            i2_q <= I_WACK;
          end
          I_WDATA: if (bit_q == 4'h8) begin
            bit_q <= '0;
            wr_stb_q <= 1'b1;
            wr_addr_q <= ptr_q;
            wr_data_q <= shift_q;
            ptr_q <= ptr_q + 8'h01;
            sda_oe <= 1'b1;
            i2_q <= I_WACK;
          end
          I_WACK: if (bit_q == 4'h1) begin
            bit_q <= '0;
            sda_oe <= 1'b0;
            i2_q <= I_WDATA;
          end
          I_RDATA: begin
            if (bit_q == 4'h8) begin
              bit_q <= '0;
              sda_oe <= 1'b0;
              i2_q <= I_RACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe <= ~tx_q[6];
            end
          end
          I_RACK: if (bit_q == 4'h1) begin
            bit_q <= '0;
            if (nack_q) i2_q <= I_IDLE;
            else begin
              ptr_q <= ptr_q + 8'h01;
              tx_q <= rd_nxt;
              sda_oe <= ~rd_nxt[7];
              i2_q <= I_RDATA;
            end
          end
        endcase
      end
    end
  end

  // Limiter and complementary PWM
  assign smp = {audio_level[7], audio_level};
  assign lim_s = {2'b00, lim_q[`APD_LIMIT_MSB:0], 1'b0};
  assign a_cl = (smp > lim_s) ? lim_s : ((smp < -lim_s) ? -lim_s : smp);
  assign duty_p = $signed(`APD_PWM_MID) + a_cl;
  assign duty_n = $signed(`APD_PWM_MID) - a_cl;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pwm_cnt_q <= '0;
      bridge_out_pos <= 1'b0;
      bridge_out_neg <= 1'b0;
      bridge_out_pos_oe <= 1'b0;
      bridge_out_neg_oe <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      bridge_out_pos <= {1'b0, pwm_cnt_q} < duty_p;
      bridge_out_neg <= {1'b0, pwm_cnt_q} < duty_n;
      bridge_out_pos_oe <= st_q == ST_PLAY;
      bridge_out_neg_oe <= st_q == ST_PLAY;
    end
  end

  // Fault pin pulls low whenever a fault holds the bridge off
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fault_n_o <= 1'b0;
      fault_n_oe <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      fault_n_o <= 1'b0;
      sda_o <= 1'b0;
      fault_n_oe <= st_q == ST_PROT || st_q == ST_LOADF;
    end
  end

  a_diag_start: assert property (@(posedge clk) disable iff (!rst_n_q)
    st_q == ST_SHDN && f_q.standby_n |=> st_q == ST_BIAS)
    else $error("diagnostic did not start on standby release");
  a_diag_hiz: assert property (@(posedge clk) disable iff (!rst_n_q)
    st_q inside {ST_BIAS, ST_CHECK} |=> !bridge_out_pos_oe && !bridge_out_neg_oe)
    else $error("bridge driven during diagnostic");
  a_one_result: assert property (@(posedge clk) disable iff (!rst_n_q)
    $onehot0(diag_stat_q))
    else $error("more than one load result");
  a_bias_end: assert property (@(posedge clk) disable iff (!rst_n_q)
    st_q == ST_BIAS && tmr_q == '0 && !abort && f_q.standby_n |=> st_q == ST_CHECK && tmr_q == TW'(CHECK_CYCLES - 1))
    else $error("bias phase did not hand over to check");
  a_check_tries: assert property (@(posedge clk) disable iff (!rst_n_q)
    tries_q <= `APD_CHECK_TRIES - 3'h1)
    else $error("check phase repeated too often");
  a_open_plays: assert property (@(posedge clk) disable iff (!rst_n_q)
    st_q == ST_CHECK && tmr_q == '0 && !abort && f_q.standby_n && cls.open_load && !f_q.large_cap
    |=> st_q == ST_PLAY ##1 bridge_out_pos_oe && !fault_n_oe)
    else $error("open load did not play");
  a_ov_alt: assert property (@(posedge clk) disable iff (!rst_n_q)
    ov_rise |=> ov_par_q != $past(ov_par_q) && ov_skip_q == ov_par_q)
    else $error("overvoltage alternation broken");
  a_abort_diag: assert property (@(posedge clk) disable iff (!rst_n_q)
    st_q inside {ST_BIAS, ST_CHECK} && abort && f_q.standby_n |=> st_q == ST_PROT ##1 fault_n_oe)
    else $error("diagnostic not aborted");
  a_oc_fault: assert property (@(posedge clk) disable iff (!rst_n_q)
    st_q == ST_PLAY && f_q.evt.oc && f_q.standby_n && !f_q.evt.uv |=> fault_stat_q.oc ##1 fault_n_oe && !bridge_out_pos_oe)
    else $error("overcurrent not handled");
  a_uv_reset: assert property (@(posedge clk) disable iff (!rst_n_q)
    f_q.evt.uv |=> lim_q == `APD_LIMIT_RST && fault_stat_q.uv)
    else $error("undervoltage did not reset registers");
  a_limit_sym: assert property (@(posedge clk) disable iff (!rst_n_q)
    a_cl <= lim_s && a_cl >= -lim_s)
    else $error("limiter magnitude exceeded");
  a_zero_phase: assert property (@(posedge clk) disable iff (!rst_n_q)
    a_cl == 9'sh000 |=> bridge_out_pos == bridge_out_neg)
    else $error("outputs out of phase at zero input");

  c_open_play: cover property (@(posedge clk) disable iff (!rst_n_q)
    st_q == ST_CHECK ##1 st_q == ST_PLAY && diag_stat_q.open_load);
  c_check_retry: cover property (@(posedge clk) disable iff (!rst_n_q) tries_q == 3'h4);
  c_abort: cover property (@(posedge clk) disable iff (!rst_n_q) st_q == ST_BIAS ##1 st_q == ST_PROT);
  c_reg_write: cover property (@(posedge clk) disable iff (!rst_n_q) wr_stb_q && wr_addr_q == `APD_REG_LIMIT);

endmodule : apd_top

/* File: test/apd_far_model.sv */
/*
  Far side of the amplifier block: the speaker load seen by the diagnostic
  comparators and the pulled-up two-wire bus shared with the host.
  Assumes the host pull signals are driven by the bench just after clk edges.
*/
`timescale 1ns/10ps

module apd_far_model
  import apd_pkg::*;
(
  // Host pulls, high means line held low
  input wire logic scl_pull,
  input wire logic sda_pull,
  // Device data line enable
  input wire logic sda_oe,
  // Load under test: 0 normal, 1 gnd, 2 supply, 3 shorted, 4 open, 5 large cap
  input wire logic [2:0] load_kind,
  // Resolved wires and comparator levels
  output logic scl_i,
  output logic sda_i,
  output apd_diag_t cmp,
  output logic large_cap
);
  // Pull-ups: a released line reads high, never the last driven value
  assign scl_i = ~scl_pull;
  assign sda_i = ~(sda_pull | sda_oe);

  always_comb begin
    cmp = '0;
    large_cap = 1'b0;
    case (load_kind)
      3'h1: cmp.short_gnd = 1'b1;
      3'h2: cmp.short_supply = 1'b1;
      3'h3: cmp.shorted_load = 1'b1;
      3'h4: cmp.open_load = 1'b1;
      3'h5: large_cap = 1'b1;
      default: ;
    endcase
  end
endmodule : apd_far_model

/* File: test/apd_top_bench.sv */
/*
  Self-checking bench of apd_top: serial register access, diagnostic runs,
  protection events and PWM duty counts.
  Assumes short diagnostic counts set through parameters and a 20 MHz clock.
*/
`timescale 1ns/10ps
`include "apd_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module apd_top_bench;
  import apd_pkg::*;
  localparam int DC = 40;
  localparam int CC = 8;
  localparam int MS = 20000;
  localparam int TMAX = 99000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic standby_n = 1'b0;
  apd_evt_t evt = '0;
  logic [7:0] audio = 8'h00;
  logic [2:0] load = 3'h0;
  logic hscl = 1'b0;
  logic hsda = 1'b0;
  logic scl_i, sda_i, sda_o, sda_oe, fault_n_o, fault_n_oe, po, poe, no, noe, large_cap;
  apd_diag_t cmp;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;

  always #25 clk = ~clk;

  apd_far_model u_far (.scl_pull(hscl), .sda_pull(hsda), .sda_oe(sda_oe), .load_kind(load),
    .scl_i(scl_i), .sda_i(sda_i), .cmp(cmp), .large_cap(large_cap));

  apd_top #(.DIAG_CYCLES(DC), .CHECK_CYCLES(CC)) u_dut (.clk(clk), .rst_n(rst_n), .standby_n(standby_n),
    .overcurrent_shutdown(evt.oc), .dc_offset_detect(evt.dc), .overtemperature_shutdown(evt.ot),
    .supply_low_event(evt.uv), .supply_high_event(evt.ov), .diag_short_gnd(cmp.short_gnd),
    .diag_short_supply(cmp.short_supply), .diag_shorted_load(cmp.shorted_load),
    .diag_open_load(cmp.open_load), .diag_large_cap(large_cap), .audio_level(audio), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
    .bridge_out_pos(po), .bridge_out_pos_oe(poe), .bridge_out_neg(no), .bridge_out_neg_oe(noe));

  task automatic results();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == TMAX) begin
      n_errors++;
      results();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : tick

  // SCL low 26 and high 14 cycles keep within the bus minimum pulse widths
  task automatic bit_tx(input logic b, output logic r);
    hsda = ~b;
    tick(13);
    hscl = 1'b0;
    tick(14);
    r = sda_i;
    hscl = 1'b1;
    tick(13);
  endtask : bit_tx

  task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_tx(d[i], q[i]);
    end
    bit_tx(m, k);
  endtask : xbyte

  task automatic i2c_start();
    hsda = 1'b0;
    tick(13);
    hscl = 1'b0;
    tick(13);
    hsda = 1'b1;
    tick(13);
    hscl = 1'b1;
    tick(13);
  endtask : i2c_start

  task automatic i2c_stop();
    hsda = 1'b1;
    tick(13);
    hscl = 1'b0;
    tick(13);
    hsda = 1'b0;
    tick(26);
  endtask : i2c_stop

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic k;
    i2c_start();
    xbyte({`APD_I2C_ADDR, 1'b0}, 1'b1, x, k);
    xbyte(a, 1'b1, x, k);
    xbyte(d, 1'b1, x, k);
    i2c_stop();
    `CHK("write ack", 1'b0, k)
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] x;
    logic [7:0] q;
    logic k;
    i2c_start();
    xbyte({`APD_I2C_ADDR, 1'b0}, 1'b1, x, k);
    xbyte(a, 1'b1, x, k);
    i2c_start();
    xbyte({`APD_I2C_ADDR, 1'b1}, 1'b1, x, k);
    xbyte(8'hFF, 1'b1, q, k);
    i2c_stop();
    `CHK("register read", e, q)
  endtask : rd_chk

  // Bounded wait for drive, or for the fault pin when f is set
  task automatic wait_end(input logic f, output int c);
    c = 0;
    while (poe !== 1'b1 && !(f && fault_n_oe === 1'b1) && c < 3000) begin
      tick(1);
      c++;
    end
  endtask : wait_end

  task automatic pwm(input logic [7:0] s, input int ep, input int en);
    int cp;
    int cn;
    logic same;
    audio = s;
    tick(300);
    cp = 0;
    cn = 0;
    same = 1'b1;
    repeat (256) begin
      tick(1);
      cp += int'(po);
      cn += int'(no);
      if (po !== no) same = 1'b0;
    end
    `CHK("pos duty", ep, cp)
    `CHK("neg duty", en, cn)
    if (s == 8'h00) `CHK("in phase", 1'b1, same)
  endtask : pwm

  task automatic hit(input apd_evt_t e, input int lo, input int hi);
    int c;
    evt = e;
    c = 0;
    // A dc fault leaves protection at once, so its pin pulse is short
    while (fault_n_oe !== 1'b1 && c < 10) begin
      tick(1);
      c++;
    end
    `CHK("fault pin", 1'b1, fault_n_oe)
    `CHK("pos hiz", 1'b0, poe)
    `CHK("neg hiz", 1'b0, noe)
    evt = '0;
    wait_end(1'b0, c);
    `CHK("recovery time", 1'b1, c >= lo && c <= hi)
    `CHK("fault released", 1'b0, fault_n_oe)
  endtask : hit

  task automatic load_run(input logic [2:0] k, input logic f, input int lo);
    int c;
    standby_n = 1'b0;
    load = k;
    tick(10);
    `CHK("shutdown drive", 1'b0, poe)
    standby_n = 1'b1;
    wait_end(1'b1, c);
    `CHK("diag length", 1'b1, c >= lo && c <= lo + 8)
    `CHK("load fault pin", f, fault_n_oe)
    `CHK("load drive", ~f, poe)
  endtask : load_run

  initial begin
    logic [7:0] x;
    logic k;
    tick(8);
    `CHK("reset sda", 1'b0, sda_oe)
    `CHK("reset fault", 1'b0, fault_n_oe)
    tick(8);
    rst_n = 1'b1;
    tick(10);
    standby_n = 1'b1;
    tick(DC / 2);
    `CHK("diag pos hiz", 1'b0, poe)
    `CHK("diag neg hiz", 1'b0, noe)
    wait_end(1'b1, n);
    `CHK("diag run", 1'b1, n + DC / 2 >= DC && n + DC / 2 <= DC + 8)
    `CHK("play drive", 1'b1, noe)
    // Host keeps off the bus for 1 ms after standby rises
    tick(MS);
    rd_chk(`APD_REG_LIMIT, `APD_LIMIT_RST);
    reg_wr(`APD_REG_LIMIT, 8'hC5);
    rd_chk(`APD_REG_LIMIT, 8'hC5);
    reg_wr(`APD_REG_FAULT, 8'hFF);
    rd_chk(`APD_REG_FAULT, 8'h00);
    rd_chk(8'h07, 8'h00);
    rd_chk(`APD_REG_DIAG, 8'h00);
    i2c_start();
    xbyte({7'h2B, 1'b0}, 1'b1, x, k);
    i2c_stop();
    `CHK("foreign address", 1'b1, k)
    // Limit 5 clamps the sample to +/-10
    pwm(8'h00, 128, 128);
    pwm(8'h03, 131, 125);
    pwm(8'h14, 138, 118);
    pwm(8'hEC, 118, 138);
    audio = 8'h00;
    hit(5'h10, DC, DC + 10);
    hit(5'h08, DC, DC + 10);
    hit(5'h04, DC, DC + 10);
    hit(5'h01, 1, 10);
    hit(5'h01, DC, DC + 10);
    rd_chk(`APD_REG_FAULT, 8'h1D);
    evt = 5'h10;
    tick(10);
    evt = '0;
    tick(15);
    evt = 5'h04;
    tick(10);
    `CHK("abort fault", 1'b1, fault_n_oe)
    tick(100);
    `CHK("abort hiz", 1'b0, poe)
    evt = '0;
    wait_end(1'b0, n);
    `CHK("abort rerun", 1'b1, n >= DC && n <= DC + 10)
    hit(5'h02, DC, DC + 10);
    rd_chk(`APD_REG_LIMIT, `APD_LIMIT_RST);
    rd_chk(`APD_REG_FAULT, 8'h02);
    load_run(3'h5, 1'b0, DC + 4 * CC);
    load_run(3'h1, 1'b1, DC + 4 * CC);
    load_run(3'h3, 1'b1, DC + 4 * CC);
    load_run(3'h2, 1'b1, DC + 4 * CC);
    tick(MS);
    `CHK("loadf holds", 1'b1, fault_n_oe)
    rd_chk(`APD_REG_DIAG, 8'h04);
    load_run(3'h4, 1'b0, DC);
    tick(MS);
    rd_chk(`APD_REG_DIAG, 8'h01);
    results();
  end
endmodule : apd_top_bench
